// *** common/sasr_pkg.sv ***
package sasr_pkg;

  // ---------------------------------------------------------------
  // Frame and conversion sizes
  // ---------------------------------------------------------------
  localparam int SASR_RES_W       = 14; // Result bits per sample
  localparam int SASR_FRAME_FALLS = 16; // Falling edges to frame end
  localparam int SASR_SYNC_W      = 3;  // Pin synchroniser depth

  // ---------------------------------------------------------------
  // Power-down entry counts (chip-select pulses, clock static)
  // ---------------------------------------------------------------
  localparam logic [2:0] SASR_NAP_PULSES   = 3'h2;
  localparam logic [2:0] SASR_SLEEP_PULSES = 3'h4;

  // ---------------------------------------------------------------
  // Frame sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SASR_ST_IDLE  = 3'h1,  // Chip select high, tracking
    SASR_ST_FRAME = 3'h2,  // Shifting and converting
    SASR_ST_DONE  = 3'h4   // Frame complete, output released
  } sasr_state_t;

endpackage : sasr_pkg

// *** common/sasr_sar_if.sv ***
`timescale 1ns/1ps

// Link between the frame sequencer and the approximation engine
interface sasr_sar_if #(
  parameter int RES_W = 14
);
  logic             start;   // Hold a new sample, clear result
  logic             step;    // Resolve one more result bit
  logic [RES_W-1:0] sample;  // Code presented at hold time
  logic [RES_W-1:0] result;  // Bits resolved so far
  logic             done;    // All bits resolved

  modport seq  (output start, output step, output sample,
                input  result, input done);
  modport conv (input  start, input step, input sample,
                output result, output done);
endinterface : sasr_sar_if

// *** logic/sasr_readout.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] Chip-select fall starts conversion and frame
// [RULE2] Chip select high: output released, tracking
// [RULE3] Output changes only on shift-clock falls
// [RULE4] Each frame fall steps the approximation
// [RULE5] Frame shifts out previous frame's result
// [RULE6] First leading zero appears at chip-select fall
// [RULE7] Clock low at start: one leading zero
// [RULE8] Clock high or running: two leading zeros
// [RULE9] Result MSB first, then trailing zeros
// [RULE10] Host holds select past sixteenth fall
// [RULE11] Host keeps start-to-clock delay
// [RULE12] Host uses fast clock, high acquisition
// [RULE13] Continuous clock windows in whole periods
// [RULE14] Burst or continuous clock, no configuration
// [RULE15] Two static-clock select pulses enter nap
// [RULE16] Four static-clock select pulses enter sleep
// [RULE17] Host wakes with one shift-clock pulse
// [RULE18] Output released after sixteenth fall
// [RULE19] Host captures next edge, strips zeros
// [RULE20] Host discards first frame after wake
module sasr_readout
  import sasr_pkg::*;
#(
  parameter int RES_W       = SASR_RES_W,
  parameter int FRAME_FALLS = SASR_FRAME_FALLS
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             cs_b_i,
  input  wire logic             sck_i,
  input  wire logic [RES_W-1:0] ain_code_i,
  output logic                  sdo_o,
  output logic                  sdo_oe_o,
  output logic                  track_o,
  output logic                  nap_o,
  output logic                  sleep_o
);

  localparam int CNT_W = $clog2(FRAME_FALLS + 1);
  localparam int PAD_W = FRAME_FALLS - RES_W;
  localparam logic [CNT_W-1:0] LAST_FALL = CNT_W'(FRAME_FALLS);
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

  // ---------------------------------------------------------------
  // Pin synchronisers and filtered levels
  // ---------------------------------------------------------------
  logic [SASR_SYNC_W-1:0] cs_sync_q;
  logic [SASR_SYNC_W-1:0] sck_sync_q;
  logic                   cs_lvl_q;
  logic                   cs_old_q;
  logic                   sck_lvl_q;
  logic                   sck_old_q;

  // A change counts once the second and third stages agree
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      cs_sync_q  <= '1;
      sck_sync_q <= '0;
      cs_lvl_q   <= 1'b1;
      cs_old_q   <= 1'b1;
      sck_lvl_q  <= 1'b0;
      sck_old_q  <= 1'b0;
    end
    else
    begin
      cs_sync_q  <= {cs_sync_q[SASR_SYNC_W-2:0], cs_b_i};
      sck_sync_q <= {sck_sync_q[SASR_SYNC_W-2:0], sck_i};
      if (cs_sync_q[1] == cs_sync_q[2])
        cs_lvl_q <= cs_sync_q[2];
      if (sck_sync_q[1] == sck_sync_q[2])
        sck_lvl_q <= sck_sync_q[2];
      cs_old_q   <= cs_lvl_q;
      sck_old_q  <= sck_lvl_q;
    end
  end

  // ---------------------------------------------------------------
  // Edge decode
  // ---------------------------------------------------------------
  // Falling edge of a filtered level, shared by both pins
  function automatic logic sasr_fell(input logic prev, input logic now);
    return prev & ~now;
  endfunction : sasr_fell

  wire cs_fall  = sasr_fell(cs_old_q, cs_lvl_q);
  wire cs_rise  = ~cs_old_q & cs_lvl_q;
  wire sck_fall = sasr_fell(sck_old_q, sck_lvl_q);
  wire sck_edge = sck_old_q ^ sck_lvl_q;

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  sasr_state_t             state_q;
  sasr_state_t             state_d;
  logic [CNT_W-1:0]        falls_q;
  logic [FRAME_FALLS-1:0]  shift_q;
  logic [RES_W-1:0]        prev_q;
  logic                    sdo_q;
  logic                    oe_q;
  logic                    track_q;

  sasr_sar_if #(.RES_W(RES_W)) sar ();

  wire in_frame   = (state_q == SASR_ST_FRAME);
  wire frame_fall = in_frame & sck_fall & ~cs_rise;
  wire last_fall  = frame_fall & ((falls_q + CNT_ONE) == LAST_FALL);

  // Frame word: one leading zero in front of the stored result
  wire [FRAME_FALLS-1:0] word_one =
    {{PAD_W{1'b0}}, prev_q} << (PAD_W - 1);
  // Clock high at chip-select fall adds a second leading zero
  wire [FRAME_FALLS-1:0] word_two  = word_one >> 1;
  wire [FRAME_FALLS-1:0] load_word =
    sck_lvl_q ? word_two : word_one;                  // [RULE7] [RULE8]

  // Next state; select rise wins over the last fall, any select rise ends the frame
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SASR_ST_IDLE:
        if (cs_fall)
          state_d = SASR_ST_FRAME;                    // [RULE1]
      SASR_ST_FRAME:
        if (cs_rise)
          state_d = SASR_ST_IDLE;
        else if (last_fall)
          state_d = SASR_ST_DONE;                     // [RULE18]
      SASR_ST_DONE:
        if (cs_rise)
          state_d = SASR_ST_IDLE;
      default:
        state_d = SASR_ST_IDLE;
    endcase
  end

  // Approximation engine control
  assign sar.start  = cs_fall;                        // [RULE1]
  assign sar.step   = frame_fall;                     // [RULE4] [RULE14]
  assign sar.sample = ain_code_i;

  sasr_sar #(
    .RES_W   (RES_W)
  ) u_sar (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .sar     (sar)
  );

  // State and fall counter
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= SASR_ST_IDLE;
      falls_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (cs_fall)
        falls_q <= '0;
      else if (frame_fall)
        falls_q <= falls_q + CNT_ONE;
    end
  end

  // Result kept only for a frame that reached its last fall
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      prev_q <= '0;
    else if (last_fall && sar.done)
      prev_q <= sar.result;                           // [RULE5] [RULE10]
  end

  // Serial output path
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      shift_q <= '0;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
    end
    else if (cs_fall)
    begin
      shift_q <= load_word;
      sdo_q   <= 1'b0;                                // [RULE6]
      oe_q    <= 1'b1;
    end
    else if (cs_rise)
    begin
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;                                // [RULE2]
    end
    else if (last_fall)
    begin
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;                                // [RULE18]
    end
    else if (frame_fall)
    begin
      sdo_q   <= shift_q[FRAME_FALLS-2];              // [RULE3] [RULE9]
      shift_q <= {shift_q[FRAME_FALLS-2:0], 1'b0};    // [RULE9]
    end
  end

  // Sample-and-hold tracks while chip select is high
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      track_q <= 1'b1;
    else
      track_q <= cs_lvl_q;                            // [RULE2]
  end

  // ---------------------------------------------------------------
  // Power-down control
  // ---------------------------------------------------------------
  logic [2:0] pulses_q;
  logic [2:0] pulses_d;
  logic       edge_seen_q;
  logic       nap_q;
  logic       sleep_q;

  // Count select pulses that saw no clock edge; any edge wakes
  always_comb
  begin
    pulses_d = pulses_q;
    if (sck_edge)
      pulses_d = '0;                                  // [RULE17]
    else if (cs_rise && !edge_seen_q &&
             pulses_q != SASR_SLEEP_PULSES)
      pulses_d = pulses_q + 3'h1;                     // [RULE15] [RULE16]
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      pulses_q    <= '0;
      edge_seen_q <= 1'b0;
      nap_q       <= 1'b0;
      sleep_q     <= 1'b0;
    end
    else
    begin
      pulses_q    <= pulses_d;
      edge_seen_q <= sck_edge | (edge_seen_q & ~cs_fall);
      nap_q       <= (pulses_d >= SASR_NAP_PULSES) &&
                     (pulses_d <  SASR_SLEEP_PULSES); // [RULE15]
      sleep_q     <= (pulses_d == SASR_SLEEP_PULSES); // [RULE16]
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign sdo_o    = sdo_q;
  assign sdo_oe_o = oe_q;
  assign track_o  = track_q;
  assign nap_o    = nap_q;
  assign sleep_o  = sleep_q;

endmodule : sasr_readout

// *** logic/sasr_sar.sv ***
`timescale 1ns/1ps

module sasr_sar
  import sasr_pkg::*;
#(
  parameter int RES_W = SASR_RES_W
) (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  sasr_sar_if.conv  sar
);

  logic [RES_W-1:0] held_q;
  logic [RES_W-1:0] res_q;
  logic [RES_W-1:0] mask_q;
  logic [RES_W-1:0] trial;
  logic             keep;

  // ---------------------------------------------------------------
  // Trial decision for the bit under test
  // ---------------------------------------------------------------
  assign trial      = res_q | mask_q;
  assign keep       = (trial <= held_q);
  assign sar.result = res_q;
  assign sar.done   = (mask_q == '0);

  // One bit resolved per step, MSB first
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      held_q <= '0;
      res_q  <= '0;
      mask_q <= '0;
    end
    else if (sar.start)
    begin
      held_q <= sar.sample;
      res_q  <= '0;
      mask_q <= {1'b1, {(RES_W-1){1'b0}}};
    end
    else if (sar.step && !sar.done)
    begin
      res_q  <= keep ? trial : res_q;
      mask_q <= mask_q >> 1;
    end
  end

endmodule : sasr_sar

// *** tb/sasr_host_model.sv ***
`timescale 1ns/1ps

// Serial master driving select and shift clock at falling edges
module sasr_host_model (
  input  wire logic clock_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      cs_b_o,
  output logic      sck_o
);
  // Deselected, clock parked low
  initial
  begin
    cs_b_o = 1'b1;
    sck_o  = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clock_i);
  endtask : gap

  // One frame of nf falls; hi keeps clock high in acquisition
  task automatic frame(input bit hi, input int nf,
                       output logic [15:0] d, output logic [15:0] e);
    d = 16'h0;
    e = 16'h0;
    sck_o = hi;
    gap(8);
    cs_b_o = 1'b0;
    gap(4);
    sck_o = 1'b1;
    gap(4);
    for (int k = 0; k < nf; k++)
    begin
      d[15-k] = sdo_i;
      e[15-k] = sdo_oe_i;
      sck_o = 1'b0;
      gap(4);
      if (k < nf - 1)
      begin
        sck_o = 1'b1;
        gap(4);
      end
    end
    gap(8);
    cs_b_o = 1'b1;
    gap(8);
  endtask : frame

  // Select pulses with the clock static
  task automatic pulse(input int n);
    repeat (n)
    begin
      cs_b_o = 1'b0;
      gap(8);
      cs_b_o = 1'b1;
      gap(8);
    end
  endtask : pulse

  // Single clock pulse ends power down
  task automatic wake();
    sck_o = 1'b1;
    gap(8);
    sck_o = 1'b0;
    gap(8);
  endtask : wake
endmodule : sasr_host_model

// *** tb/sasr_readout_assertions.sv ***
`timescale 1ns/1ps

module sasr_readout_assertions
  import sasr_pkg::*;
#(
  parameter int RES_W       = SASR_RES_W,
  parameter int FRAME_FALLS = SASR_FRAME_FALLS
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             cs_b_i,
  input  wire logic             sck_i,
  input  wire logic [RES_W-1:0] ain_code_i,
  input  wire logic             sdo_o,
  input  wire logic             sdo_oe_o,
  input  wire logic             track_o,
  input  wire logic             nap_o,
  input  wire logic             sleep_o
);
  logic [4:0] falls_q;  // Pin clock falls since select fell
  logic [3:0] age_q;    // Cycles since last pin fall

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // Pin edge bookkeeping
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i || $fell(cs_b_i)) falls_q <= 5'h0;
    else if ($fell(sck_i) && falls_q < 5'h1F) falls_q <= falls_q + 5'h1;
    if (!rst_b_i) age_q <= 4'hF;
    else if ($fell(sck_i) || $fell(cs_b_i)) age_q <= 4'h0;
    else if (age_q < 4'hF) age_q <= age_q + 4'h1;
  end

  property p_idle;
    cs_b_i[*6] |-> !sdo_oe_o && track_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("output driven or hold active while deselected");
  property p_off_zero;
    !sdo_oe_o |-> !sdo_o;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("data high while released");
  property p_start;
    $fell(cs_b_i) ##1 !cs_b_i[*6] |-> sdo_oe_o && !sdo_o && !track_o;
  endproperty
  a_start: assert property (p_start)
    else $error("no leading zero after select fall");
  property p_edge;
    $changed(sdo_o) && sdo_oe_o && $past(sdo_oe_o) |-> age_q inside {[2:6]};
  endproperty
  a_edge: assert property (p_edge)
    else $error("data moved away from a clock fall");
  property p_release;
    (falls_q == FRAME_FALLS)[*7] |-> !sdo_oe_o;
  endproperty
  a_release: assert property (p_release)
    else $error("output still driven after last fall");
  property p_frame_on;
    !cs_b_i[*6] ##0 (falls_q < FRAME_FALLS) |-> sdo_oe_o;
  endproperty
  a_frame_on: assert property (p_frame_on)
    else $error("output not driven inside frame");
  property p_wake;
    $changed(sck_i) |-> ##[1:6] (!nap_o && !sleep_o);
  endproperty
  a_wake: assert property (p_wake)
    else $error("clock edge did not end power down");
  property p_excl;
    !(nap_o && sleep_o);
  endproperty
  a_excl: assert property (p_excl)
    else $error("nap and sleep both set");

  c_release: cover property (falls_q == FRAME_FALLS && !sdo_oe_o);
  c_nap: cover property ($rose(nap_o));
  c_sleep: cover property ($rose(sleep_o));
endmodule : sasr_readout_assertions

bind sasr_readout sasr_readout_assertions #(
  .RES_W(RES_W), .FRAME_FALLS(FRAME_FALLS)
) u_sasr_readout_assertions (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .sck_i(sck_i),
  .ain_code_i(ain_code_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .track_o(track_o), .nap_o(nap_o), .sleep_o(sleep_o)
);

// *** tb/sasr_readout_tb_top.sv ***
`timescale 1ns/1ps

module sasr_readout_tb_top;
  logic        clock_i    = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic [13:0] ain_code_i = 14'h0;
  logic        cs_b, sck, sdo, sdo_oe, track, nap, sleep;
  wire         sdo_line = sdo_oe ? sdo : 1'bz;
  int          num_errors  = 0;
  int          comparisons = 0;
  logic [15:0] d, e;

  always #10 clock_i = ~clock_i;

  sasr_readout u_sasr_readout (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sck_i(sck),
    .ain_code_i(ain_code_i), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .track_o(track), .nap_o(nap), .sleep_o(sleep));
  sasr_host_model u_sasr_host_model (
    .clock_i(clock_i), .sdo_i(sdo_line), .sdo_oe_i(sdo_oe),
    .cs_b_o(cs_b), .sck_o(sck));

  task automatic check(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // Hold a code and run one frame
  task automatic run(input bit hi, input int nf, input logic [13:0] c);
    ain_code_i = c;
    u_sasr_host_model.frame(hi, nf, d, e);
  endtask : run

  task automatic t_reset();
    check("rst", {11'h0, sdo_oe, sdo, track, nap, sleep}, 16'h0004);
  endtask : t_reset

  // First frame empty, then one zero, result, trailing zero
  task automatic t_low();
    run(1'b0, 16, 14'h2A5C);
    check("first", d, 16'h0000);
    check("enable", e, 16'hFFFF);
    run(1'b0, 16, 14'h1337);
    check("one_zero", d, {1'b0, 14'h2A5C, 1'b0});
  endtask : t_low

  task automatic t_high();
    run(1'b1, 16, 14'h3FFF);
    check("two_zero", d, {2'b00, 14'h1337});
    check("enable_hi", e, 16'hFFFF);
  endtask : t_high

  // Early release keeps the older result
  task automatic t_abort();
    run(1'b1, 5, 14'h0001);
    check("cut", {d[15:11], 11'h0}, 16'h3800);
    run(1'b0, 16, 14'h0000);
    check("kept", d, {1'b0, 14'h3FFF, 1'b0});
  endtask : t_abort

  task automatic t_power();
    u_sasr_host_model.pulse(2);
    check("nap", {14'h0, nap, sleep}, 16'h0002);
    u_sasr_host_model.pulse(2);
    check("sleep", {14'h0, nap, sleep}, 16'h0001);
    u_sasr_host_model.wake();
    check("woke", {14'h0, nap, sleep}, 16'h0000);
    u_sasr_host_model.pulse(2);
    check("nap_again", {14'h0, nap, sleep}, 16'h0002);
    u_sasr_host_model.wake();
    check("nap_woke", {14'h0, nap, sleep}, 16'h0000);
  endtask : t_power

  // Main sequence
  initial
  begin
    repeat (2) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (2) @(negedge clock_i);
    t_reset();
    t_low();
    t_high();
    t_abort();
    t_power();
    conclude();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(negedge clock_i);
    num_errors++;
    conclude();
  end
endmodule : sasr_readout_tb_top
